//--- cwd_decoder.sv
/*
 * configuration word decoder: latches packed words at reset, decodes settings,
 * answers table reads of the three words and the identity word.
 * assumes: non-volatile words are stable while a load runs after reset release.
 */
`timescale 1ns/100ps

// Overview of operation
// - initial oscillator code picks start-up clock; 110 is reserved
// - one-way option lets pin lock set once; maps then refuse writes
// - brown-out active only when both enables are 11; mixed reserved
// - primary oscillator code: off, high-speed, standard crystal, external clock
// - end-page bit picks segment above or below the boundary page
// - config page protect at 0 guards last page when protection on
// - segment protect disable at 1 turns segmented protection off
// - config page protected when end-page set or boundary hits it
// - boundary page field counts pages of 256 instruction words
// - window width code sets open share: 25, 37.5, 50, 75 percent
// - secondary select: crystal circuit at 1, digital clock input at 0
// - battery brown-out detector follows its enable bit
// - deep-sleep postscaler doubles per code, from 1:32 upward
// - upper byte of every configuration word reads all ones
// - fields are program-once and read one when unprogrammed
// - every reset reloads configuration words from non-volatile memory
// - early windowed watchdog clear resets; in-window clear restarts count
// - identity word holds family id in 15:8, part id in 7:0
module cwd_decoder #(
    parameter logic [7:0]  FAMILY_ID  = 8'h5A, // arbitrary value
    parameter logic [7:0]  PART_ID    = 8'hA5, // arbitrary value
    parameter logic [6:0]  LAST_PAGE  = 7'h57,
    parameter int unsigned WDOG_CNT_W = 16
) (
    // clock and reset
    input  wire logic                           CLOCK,
    input  wire logic                           RESETN,
    // non-volatile configuration words
    input  wire logic [cwd_pkg::WORD_W-1:0]     NV_OSC_WORD,
    input  wire logic [cwd_pkg::WORD_W-1:0]     NV_PROT_WORD,
    input  wire logic [cwd_pkg::WORD_W-1:0]     NV_DSLP_WORD,
    // table-access read path
    input  wire logic                           TBL_RD,
    input  wire logic [1:0]                     TBL_SEL,
    output logic [cwd_pkg::WORD_W-1:0]          TBL_DATA,
    output logic                                TBL_VALID,
    // decoded oscillator settings
    output logic [2:0]                          INITIAL_OSC_SELECT,
    output logic [1:0]                          PRIMARY_OSC_MODE,
    output logic                                SECONDARY_OSC_XTAL,
    output logic                                SECONDARY_CLOCK_INPUT,
    output logic                                CONFIG_READY,
    // brown-out
    output logic                                BROWNOUT_ACTIVE,
    output logic                                BROWNOUT_RESERVED,
    output logic                                BATTERY_BROWNOUT_ENABLE,
    input  wire logic                           DEEP_SLEEP,
    output logic                                BROWNOUT_DETECT_EN,
    // write protection check
    input  wire logic [6:0]                     WR_PAGE,
    input  wire logic                           WR_CONFIG_PAGE,
    output logic                                WR_PROTECTED,
    // watchdog window
    output logic [3:0]                          WATCHDOG_WINDOW_EIGHTHS,
    input  wire logic                           WINDOW_MODE,
    input  wire logic [WDOG_CNT_W-1:0]          WDOG_COUNT,
    input  wire logic [WDOG_CNT_W-1:0]          WDOG_PERIOD,
    input  wire logic                           WATCHDOG_CLEAR_INSTR,
    output logic                                WDOG_RESTART,
    output logic                                WDOG_EARLY_RESET,
    // deep sleep
    output logic [5:0]                          DEEP_SLEEP_WDOG_LOG2_DIV,
    // pin-select lock
    input  wire logic                           PIN_UNLOCKED,
    input  wire logic                           PIN_LOCK_SET,
    input  wire logic                           PIN_LOCK_CLR,
    input  wire logic                           PIN_MAP_WR,
    output logic                                PIN_SELECT_LOCK,
    output logic                                PIN_MAP_WR_OK
);
    localparam int unsigned W  = cwd_pkg::WORD_W;
    localparam int unsigned LC = cwd_pkg::LOAD_CYCLES;
    localparam int unsigned LW = (LC < 2) ? 1 : $clog2(LC + 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        cwd_pkg::cwd_state_t state;
        logic [LW-1:0]       wait_cnt;
        logic [W-1:0]        osc_word;
        logic [W-1:0]        prot_word;
        logic [W-1:0]        dslp_word;
        logic [W-1:0]        rd_data;
        logic                rd_valid;
    } cwd_st_t;

    cwd_st_t st_q;
    cwd_st_t st_d;

    logic [W-1:0] nv_words  [cwd_pkg::NUM_WORDS];
    logic [W-1:0] cfg_words [cwd_pkg::NUM_WORDS];
    logic [W-1:0] load_words[cwd_pkg::NUM_WORDS];

    assign nv_words[0] = NV_OSC_WORD;
    assign nv_words[1] = NV_PROT_WORD;
    assign nv_words[2] = NV_DSLP_WORD;
    assign cfg_words[0] = st_q.osc_word;
    assign cfg_words[1] = st_q.prot_word;
    assign cfg_words[2] = st_q.dslp_word;

    // unimplemented upper byte forced to ones on load
    genvar gi;
    generate
        for (gi = 0; gi < cwd_pkg::NUM_WORDS; gi++)
        begin : g_load
            assign load_words[gi] = {cwd_pkg::UPPER_ONES,
                                     nv_words[gi][cwd_pkg::UPPER_LSB-1:0]};
        end
    endgenerate

    // ------------------------------------------------------------
    // load sequence and table read
    // ------------------------------------------------------------
    always_comb
    begin
        st_d          = st_q;
        st_d.rd_valid = 1'b0;
        case (st_q.state)
            cwd_pkg::ST_IDLE:
            begin
                st_d.state    = cwd_pkg::ST_LOAD;
                st_d.wait_cnt = '0;
            end
            cwd_pkg::ST_LOAD:
            begin
                // sample after a settle time; apart from reset, words only change here
                if (st_q.wait_cnt == LW'(LC - 1))
                begin
                    st_d.osc_word  = load_words[0];
                    st_d.prot_word = load_words[1];
                    st_d.dslp_word = load_words[2];
                    st_d.state     = cwd_pkg::ST_RUN;
                end
                else
                    st_d.wait_cnt = st_q.wait_cnt + LW'(1);
            end
            cwd_pkg::ST_RUN:
            begin
                if (TBL_RD)
                begin
                    st_d.rd_valid = 1'b1;
                    if (TBL_SEL == cwd_pkg::SEL_OSC)
                        st_d.rd_data = cfg_words[0];
                    else if (TBL_SEL == cwd_pkg::SEL_PROT)
                        st_d.rd_data = cfg_words[1];
                    else if (TBL_SEL == cwd_pkg::SEL_DSLP)
                        st_d.rd_data = cfg_words[2];
                    else
                        st_d.rd_data = {cwd_pkg::UPPER_ONES, FAMILY_ID, PART_ID};
                end
            end
            default:
                st_d.state = cwd_pkg::ST_IDLE;
        endcase
    end

    // erased words read as ones until the first load
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            st_q           <= '0;
            st_q.state     <= cwd_pkg::ST_IDLE;
            st_q.osc_word  <= cwd_pkg::ERASED_WORD;
            st_q.prot_word <= cwd_pkg::ERASED_WORD;
            st_q.dslp_word <= cwd_pkg::ERASED_WORD;
        end
        else
            st_q <= st_d;
    end

    assign TBL_DATA     = st_q.rd_data;
    assign TBL_VALID    = st_q.rd_valid;
    assign CONFIG_READY = (st_q.state == cwd_pkg::ST_RUN);

    // ------------------------------------------------------------
    // oscillator decode
    // ------------------------------------------------------------
    logic [2:0] osc_code;
    logic       bor_main;
    logic       bor_ovr;

    always_comb
    begin
        osc_code = st_q.osc_word[cwd_pkg::OSC_INIT_LSB +: 3];
        // a reserved code falls back to fast rc so the core still starts
        if (osc_code == cwd_pkg::CLK_RESERVED)
            INITIAL_OSC_SELECT = cwd_pkg::CLK_FRC;
        else
            INITIAL_OSC_SELECT = osc_code;
    end

    assign PRIMARY_OSC_MODE      = st_q.osc_word[cwd_pkg::OSC_PRIM_LSB +: 2];
    assign SECONDARY_OSC_XTAL    = st_q.prot_word[cwd_pkg::PR_SECONDARY_OSC_BIT];
    assign SECONDARY_CLOCK_INPUT = !st_q.prot_word[cwd_pkg::PR_SECONDARY_OSC_BIT];

    // ------------------------------------------------------------
    // brown-out
    // ------------------------------------------------------------
    assign bor_main = st_q.prot_word[cwd_pkg::PR_BOR_BIT];
    assign bor_ovr  = st_q.osc_word[cwd_pkg::OSC_BOROVR_BIT];
    // mixed pairs treated as off; makes them a programming fault
    assign BROWNOUT_ACTIVE         = bor_main && bor_ovr;
    assign BROWNOUT_RESERVED       = bor_main ^ bor_ovr;
    assign BROWNOUT_DETECT_EN      = bor_main && bor_ovr && !DEEP_SLEEP;
    assign BATTERY_BROWNOUT_ENABLE = st_q.prot_word[cwd_pkg::PR_VBOR_BIT];

    // ------------------------------------------------------------
    // segmented write protection
    // ------------------------------------------------------------
    logic             end_sel;
    logic             cfg_prot_n;
    logic             seg_dis;
    logic [6:0]       bound;
    logic             in_seg;
    logic             cfg_page_hit;

    always_comb
    begin
        end_sel    = st_q.prot_word[cwd_pkg::PR_END_BIT];
        cfg_prot_n = st_q.prot_word[cwd_pkg::PR_CFG_BIT];
        seg_dis    = st_q.prot_word[cwd_pkg::PR_DIS_BIT];
        bound      = st_q.prot_word[cwd_pkg::PR_PAGE_LSB +: cwd_pkg::PAGE_W];
        if (end_sel)
            in_seg = (WR_PAGE >= bound);
        else
            in_seg = (WR_PAGE >= cwd_pkg::PAGE_ZERO) && (WR_PAGE <= bound);
        // last page holds the config words
        cfg_page_hit = WR_CONFIG_PAGE || (WR_PAGE == LAST_PAGE);
        WR_PROTECTED = 1'b0;
        if (!seg_dis)
        begin
            if (in_seg && !WR_CONFIG_PAGE)
                WR_PROTECTED = 1'b1;
            if (cfg_page_hit && !cfg_prot_n)
                WR_PROTECTED = 1'b1;
            if (cfg_page_hit && (end_sel || bound == LAST_PAGE))
                WR_PROTECTED = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // watchdog window and deep-sleep postscaler
    // ------------------------------------------------------------
    always_comb
    begin
        case (st_q.prot_word[cwd_pkg::PR_WIN_LSB +: 2])
            2'b11:   WATCHDOG_WINDOW_EIGHTHS = cwd_pkg::WIN_25;
            2'b10:   WATCHDOG_WINDOW_EIGHTHS = cwd_pkg::WIN_37;
            2'b01:   WATCHDOG_WINDOW_EIGHTHS = cwd_pkg::WIN_50;
            default: WATCHDOG_WINDOW_EIGHTHS = cwd_pkg::WIN_75;
        endcase
    end

    // divide ratio as a power of two: code 0 is 2^5 = 1:32
    assign DEEP_SLEEP_WDOG_LOG2_DIV =
        6'(st_q.dslp_word[cwd_pkg::DS_POST_LSB +: cwd_pkg::DS_POST_W])
        + 6'(cwd_pkg::DS_BASE_LOG2);

    cwd_wdog_window #(
        .CNT_W        (WDOG_CNT_W)
    ) u_win (
        .clk          (CLOCK),
        .rst_n        (RESETN),
        .window_en    (WINDOW_MODE),
        .open_eighths (WATCHDOG_WINDOW_EIGHTHS),
        .count        (WDOG_COUNT),
        .period       (WDOG_PERIOD),
        .clear_req    (WATCHDOG_CLEAR_INSTR),
        .clear_ok     (WDOG_RESTART),
        .early_reset  (WDOG_EARLY_RESET)
    );

    // ------------------------------------------------------------
    // pin-select lock
    // ------------------------------------------------------------
    cwd_pin_lock u_lock (
        .clk          (CLOCK),
        .rst_n        (RESETN),
        .one_way      (st_q.osc_word[cwd_pkg::OSC_LOCK1W_BIT]),
        .unlocked     (PIN_UNLOCKED),
        .set_req      (PIN_LOCK_SET),
        .clr_req      (PIN_LOCK_CLR),
        .map_wr_req   (PIN_MAP_WR),
        .lock         (PIN_SELECT_LOCK),
        .map_wr_ok    (PIN_MAP_WR_OK)
    );
endmodule

//--- cwd_decoder_props.sv
/*
 * port checker for the config word decoder.
 * assumes: bound to cwd_decoder from the bench top file, one clock domain.
 */
`timescale 1ns/100ps
module cwd_decoder_props #(
    parameter logic [7:0] FAMILY_ID = 8'h5A,
    parameter logic [7:0] PART_ID   = 8'hA5
) (
    // clock, reset and table path
    input wire logic        CLOCK,
    input wire logic        RESETN,
    input wire logic        TBL_RD,
    input wire logic [1:0]  TBL_SEL,
    input wire logic [23:0] TBL_DATA,
    input wire logic        TBL_VALID,
    input wire logic        CONFIG_READY,
    // decoded settings
    input wire logic [2:0]  INITIAL_OSC_SELECT,
    input wire logic        SECONDARY_OSC_XTAL,
    input wire logic        SECONDARY_CLOCK_INPUT,
    input wire logic        BROWNOUT_ACTIVE,
    input wire logic        BROWNOUT_RESERVED,
    input wire logic        DEEP_SLEEP,
    input wire logic        BROWNOUT_DETECT_EN,
    input wire logic [3:0]  WATCHDOG_WINDOW_EIGHTHS,
    input wire logic [5:0]  DEEP_SLEEP_WDOG_LOG2_DIV,
    // watchdog and pin lock
    input wire logic        WATCHDOG_CLEAR_INSTR,
    input wire logic        WDOG_RESTART,
    input wire logic        WDOG_EARLY_RESET,
    input wire logic        PIN_SELECT_LOCK,
    input wire logic        PIN_MAP_WR_OK
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    a_osc_no_reserved: assert property (INITIAL_OSC_SELECT != 3'b110)
        else $error("reserved start clock code decoded");
    a_read_answer: assert property (TBL_RD && CONFIG_READY |=> TBL_VALID)
        else $error("table read not answered");
    a_read_refused: assert property (TBL_VALID |-> $past(TBL_RD && CONFIG_READY))
        else $error("table answer without accepted read");
    a_upper_ones: assert property (TBL_VALID |-> TBL_DATA[23:16] == 8'hFF)
        else $error("upper byte not all ones");
    a_identity_word: assert property (TBL_VALID && $past(TBL_SEL) == 2'h3
        |-> TBL_DATA[15:0] == {FAMILY_ID, PART_ID}) else $error("identity word wrong");
    a_bor_detect: assert property (BROWNOUT_DETECT_EN
        |-> BROWNOUT_ACTIVE && !BROWNOUT_RESERVED && !DEEP_SLEEP) else $error("bor detect");
    a_secondary_osc_modes: assert property (SECONDARY_OSC_XTAL != SECONDARY_CLOCK_INPUT)
        else $error("secondary modes overlap");
    a_window_share: assert property (WATCHDOG_WINDOW_EIGHTHS inside {4'h2, 4'h3, 4'h4, 4'h6})
        else $error("window share off table");
    a_early_clear: assert property (WATCHDOG_CLEAR_INSTR && !WDOG_RESTART |=> WDOG_EARLY_RESET)
        else $error("early clear without reset");
    a_lock_blocks: assert property (PIN_SELECT_LOCK |-> !PIN_MAP_WR_OK)
        else $error("map write allowed while locked");
    a_decode_steady: assert property (CONFIG_READY && $past(CONFIG_READY)
        |-> $stable(INITIAL_OSC_SELECT) && $stable(DEEP_SLEEP_WDOG_LOG2_DIV))
        else $error("decode moved between resets");
endmodule

//--- cwd_decoder_test.sv
/*
 * self-checking bench for the config word decoder.
 * assumes: design sources and cwd_decoder_props compiled first.
 */
`timescale 1ns/100ps
module cwd_decoder_test;
    localparam logic [7:0] FAM  = 8'h3C; // arbitrary value
    localparam logic [7:0] PART = 8'hC3; // arbitrary value
    logic        CLOCK, RESETN, TBL_RD, DEEP_SLEEP, WR_CONFIG_PAGE, WINDOW_MODE;
    logic        WATCHDOG_CLEAR_INSTR, PIN_UNLOCKED, PIN_LOCK_SET, PIN_LOCK_CLR, PIN_MAP_WR;
    logic        TBL_VALID, SECONDARY_OSC_XTAL, SECONDARY_CLOCK_INPUT, CONFIG_READY;
    logic        BROWNOUT_ACTIVE, BROWNOUT_RESERVED, BATTERY_BROWNOUT_ENABLE, BROWNOUT_DETECT_EN;
    logic        WR_PROTECTED, WDOG_RESTART, WDOG_EARLY_RESET, PIN_SELECT_LOCK, PIN_MAP_WR_OK;
    logic [23:0] NV_OSC_WORD, NV_PROT_WORD, NV_DSLP_WORD, TBL_DATA, ow, pw, dw;
    logic [15:0] WDOG_COUNT, WDOG_PERIOD;
    logic [6:0]  WR_PAGE;
    logic [5:0]  DEEP_SLEEP_WDOG_LOG2_DIV;
    logic [3:0]  WATCHDOG_WINDOW_EIGHTHS, e;
    logic [2:0]  INITIAL_OSC_SELECT;
    logic [1:0]  TBL_SEL, PRIMARY_OSC_MODE;
    logic [23:0] exp_q [$];
    logic [23:0] w [4];
    logic [3:0]  win_tab [4] = '{4'h6, 4'h4, 4'h3, 4'h2};
    int          err_total, checked, cycles, seed;

    cwd_decoder #(.FAMILY_ID(FAM), .PART_ID(PART)) dut (.*);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // config page guard wins over segment bounds; boundary page itself avoided
    function automatic logic prot_exp(input logic [15:0] p, input logic [6:0] pg, input logic c);
        if (p[13])
            return 1'b0;
        if (c)
            return p[15] | !p[14] | (p[6:0] == 7'h57);
        return p[15] ? (pg > p[6:0]) : (pg < p[6:0]);
    endfunction

    task automatic do_reset(input int n);
        RESETN = 1'b0;
        repeat (n) @(negedge CLOCK);
        check(CONFIG_READY, 1'b0);
        check(INITIAL_OSC_SELECT, 3'b111);
        RESETN = 1'b1;
        TBL_RD = 1'b1;
        repeat (2) @(negedge CLOCK);
        TBL_RD = 1'b0;
        repeat (8) if (CONFIG_READY !== 1'b1) @(negedge CLOCK);
        check(CONFIG_READY, 1'b1);
    endtask

    // ------------------------------------------------------------
    // clock, timeout and answer monitor
    // ------------------------------------------------------------
    initial
    begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end

    always @(negedge CLOCK)
    begin
        cycles++;
        if (cycles > 4000)
        begin
            err_total++;
            finish_test();
        end
        if (TBL_VALID === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(1'b1, 1'b0);
            else
                check(TBL_DATA, exp_q.pop_front());
        end
    end

    // ------------------------------------------------------------
    // main sequence: one reload per code
    // ------------------------------------------------------------
    initial
    begin
        {RESETN, TBL_RD, TBL_SEL, DEEP_SLEEP, WR_CONFIG_PAGE, WR_PAGE, WINDOW_MODE} = '0;
        {WATCHDOG_CLEAR_INSTR, PIN_UNLOCKED, PIN_LOCK_SET, PIN_LOCK_CLR, PIN_MAP_WR} = '0;
        {WDOG_COUNT, WDOG_PERIOD, NV_OSC_WORD, NV_PROT_WORD, NV_DSLP_WORD} = '0;
        seed = 32'h4287DBF0;
        for (int i = 0; i < 8; i++)
        begin
            ow = $random(seed);
            pw = $random(seed);
            dw = $random(seed);
            {ow[10:8], ow[4:3], ow[1:0]} = {i[2:0], i[2:1], i[1:0]};
            {pw[15:10], pw[8:7]} = {i[0], i[1], i[2], i[2], i[1:0], i[0], i[1]};
            pw[6:0] = {2'b00, pw[4:0]} + 7'h08;
            {ow[2], pw[9]} = 2'b11;
            {NV_OSC_WORD, NV_PROT_WORD, NV_DSLP_WORD} = {ow, pw, dw};
            do_reset(i == 0 ? 16 : 3);
            {NV_OSC_WORD, NV_PROT_WORD, NV_DSLP_WORD} = {$random(seed), $random(seed), dw};
            DEEP_SLEEP = i[0];
            e = win_tab[pw[11:10]];
            #1 check(INITIAL_OSC_SELECT, (i == 6) ? 3'h0 : i[2:0]);
            check(PRIMARY_OSC_MODE, ow[1:0]);
            check({SECONDARY_OSC_XTAL, SECONDARY_CLOCK_INPUT}, {pw[8], !pw[8]});
            check(BATTERY_BROWNOUT_ENABLE, pw[7]);
            check({BROWNOUT_ACTIVE, BROWNOUT_RESERVED}, {ow[3] & pw[12], ow[3] ^ pw[12]});
            check(BROWNOUT_DETECT_EN, ow[3] & pw[12] & !i[0]);
            check(WATCHDOG_WINDOW_EIGHTHS, e);
            check(DEEP_SLEEP_WDOG_LOG2_DIV, {1'b0, dw[4:0]} + 6'h05);
            for (int k = 0; k < 3; k++)
            begin
                WR_PAGE = (k == 1) ? pw[6:0] + 7'h04 : pw[6:0] - 7'h04;
                WR_CONFIG_PAGE = (k == 2);
                #1 check(WR_PROTECTED, prot_exp(pw[15:0], WR_PAGE, WR_CONFIG_PAGE));
            end
            {w[0], w[1], w[2], w[3]} = {ow, pw, dw, 8'hFF, FAM, PART};
            @(negedge CLOCK);
            for (int s = 0; s < 4; s++)
            begin
                TBL_SEL = s[1:0];
                TBL_RD = 1'b1;
                exp_q.push_back({8'hFF, w[s][15:0]});
                @(negedge CLOCK);
            end
            TBL_RD = 1'b0;
            WDOG_PERIOD = 16'h0100;
            for (int k = 0; k < 3; k++)
            begin
                WINDOW_MODE = (k != 2);
                WDOG_COUNT = {7'h00, 4'h8 - e, 5'h00} - {15'h0000, k != 1};
                WATCHDOG_CLEAR_INSTR = 1'b1;
                #1 check(WDOG_RESTART, k != 0);
                @(negedge CLOCK);
                WATCHDOG_CLEAR_INSTR = 1'b0;
                check(WDOG_EARLY_RESET, k == 0);
                @(negedge CLOCK);
            end
            {PIN_UNLOCKED, PIN_MAP_WR, PIN_LOCK_SET} = 3'b111;
            #1 check({PIN_SELECT_LOCK, PIN_MAP_WR_OK}, 2'b01);
            @(negedge CLOCK);
            {PIN_LOCK_SET, PIN_LOCK_CLR} = 2'b01;
            #1 check({PIN_SELECT_LOCK, PIN_MAP_WR_OK}, 2'b10);
            @(negedge CLOCK);
            PIN_LOCK_CLR = 1'b0;
            #1 check({PIN_SELECT_LOCK, PIN_MAP_WR_OK}, {ow[4], !ow[4]});
            @(negedge CLOCK);
        end
        repeat (2) @(negedge CLOCK);
        check(exp_q.size(), 24'h0);
        finish_test();
    end
endmodule

bind cwd_decoder cwd_decoder_props #(.FAMILY_ID(FAMILY_ID), .PART_ID(PART_ID)) props (.*);

//--- cwd_pin_lock.sv
/*
 * pin-select lock keeper with one-way policy.
 * assumes: unlock sequence detection lives in the oscillator control block.
 */
`timescale 1ns/100ps
module cwd_pin_lock (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // policy and software requests
    input  wire logic one_way,
    input  wire logic unlocked,
    input  wire logic set_req,
    input  wire logic clr_req,
    input  wire logic map_wr_req,
    // results
    output logic      lock,
    output logic      map_wr_ok
);
    typedef struct packed {
        logic lock;
        logic used;
    } cwd_lock_st_t;

    cwd_lock_st_t st_q;
    cwd_lock_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (unlocked)
        begin
            if (set_req && !(one_way && st_q.used))
            begin
                st_d.lock = 1'b1;
                st_d.used = 1'b1;
            end
            else if (clr_req && !one_way)
                st_d.lock = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign lock      = st_q.lock;
    assign map_wr_ok = map_wr_req && !st_q.lock && !(one_way && st_q.used);
endmodule

//--- cwd_pkg.sv
/*
 * config word decoder package: word selects, field positions, codes, timing constants.
 * assumes: a single system clock domain, non-volatile words presented at reset.
 */
package cwd_pkg;

    // ------------------------------------------------------------
    // widths and word selects
    // ------------------------------------------------------------
    localparam int unsigned WORD_W   = 24;
    localparam int unsigned NUM_WORDS = 3;
    localparam logic [1:0]  SEL_OSC   = 2'h0;
    localparam logic [1:0]  SEL_PROT  = 2'h1;
    localparam logic [1:0]  SEL_DSLP  = 2'h2;
    localparam logic [1:0]  SEL_ID    = 2'h3;

    // ------------------------------------------------------------
    // oscillator word fields
    // ------------------------------------------------------------
    localparam int unsigned OSC_INIT_LSB   = 8;
    localparam int unsigned OSC_LOCK1W_BIT = 4;
    localparam int unsigned OSC_BOROVR_BIT = 3;
    localparam int unsigned OSC_PRIM_LSB   = 0;

    // ------------------------------------------------------------
    // protection word fields
    // ------------------------------------------------------------
    localparam int unsigned PR_END_BIT    = 15;
    localparam int unsigned PR_CFG_BIT    = 14;
    localparam int unsigned PR_DIS_BIT    = 13;
    localparam int unsigned PR_BOR_BIT    = 12;
    localparam int unsigned PR_WIN_LSB    = 10;
    localparam int unsigned PR_SECONDARY_OSC_BIT   = 8;
    localparam int unsigned PR_VBOR_BIT   = 7;
    localparam int unsigned PR_PAGE_LSB   = 0;
    localparam int unsigned PAGE_W        = 7;

    // ------------------------------------------------------------
    // deep sleep word and identity word
    // ------------------------------------------------------------
    localparam int unsigned DS_POST_LSB  = 0;
    localparam int unsigned DS_POST_W    = 5;
    localparam int unsigned ID_FAM_LSB   = 8;
    localparam int unsigned ID_PART_LSB  = 0;
    localparam int unsigned UPPER_LSB    = 16;
    localparam logic [7:0]  UPPER_ONES   = 8'hFF;
    localparam logic [WORD_W-1:0] ERASED_WORD = 24'hFFFFFF;
    localparam logic [4:0]  DS_BASE_LOG2 = 5'h05;
    localparam logic [PAGE_W-1:0] PAGE_ZERO = 7'h00;

    // ------------------------------------------------------------
    // decoded enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CLK_FRC        = 3'b000,
        CLK_FRC_PLL    = 3'b001,
        CLK_PRIMARY    = 3'b010,
        CLK_PRIM_PLL   = 3'b011,
        CLK_SECONDARY  = 3'b100,
        CLK_LOW_POWER_RC_OSC       = 3'b101,
        CLK_RESERVED   = 3'b110,
        CLK_FRC_DIV    = 3'b111
    } cwd_clk_t;

    typedef enum logic [1:0] {
        PRIM_EXT_CLOCK = 2'b00,
        PRIM_STD_XTAL  = 2'b01,
        PRIM_HS_XTAL   = 2'b10,
        PRIM_OFF       = 2'b11
    } cwd_prim_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } cwd_state_t;

    // window open share in eighths of the watchdog period
    localparam logic [3:0] WIN_25   = 4'h2;
    localparam logic [3:0] WIN_37   = 4'h3;
    localparam logic [3:0] WIN_50   = 4'h4;
    localparam logic [3:0] WIN_75   = 4'h6;
    localparam logic [3:0] WIN_FULL = 4'h8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ     = 125;
    localparam int unsigned LOAD_NS     = 16;
    localparam int unsigned LOAD_CYCLES =
        ((LOAD_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (LOAD_NS * CLK_MHZ + 999) / 1000;

endpackage

//--- cwd_wdog_window.sv
/*
 * windowed watchdog clear checker.
 * assumes: period count and clear pulse come from the watchdog counter outside.
 */
`timescale 1ns/100ps
module cwd_wdog_window #(
    parameter int unsigned CNT_W = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // configuration
    input  wire logic             window_en,
    input  wire logic [3:0]       open_eighths,
    // watchdog state
    input  wire logic [CNT_W-1:0] count,
    input  wire logic [CNT_W-1:0] period,
    input  wire logic             clear_req,
    // results
    output logic                  clear_ok,
    output logic                  early_reset
);
    typedef struct packed {
        logic early;
    } cwd_win_st_t;

    cwd_win_st_t st_q;
    cwd_win_st_t st_d;
    logic [CNT_W+3:0] closed_len;
    logic [CNT_W+3:0] scaled_cnt;
    logic             in_window;

    // window sits at the end of the period; compare in eighths to avoid a divider
    always_comb
    begin
        closed_len = (CNT_W+4)'(period) * (CNT_W+4)'(cwd_pkg::WIN_FULL - open_eighths);
        scaled_cnt = (CNT_W+4)'(count) * (CNT_W+4)'(cwd_pkg::WIN_FULL);
        in_window  = !window_en || (scaled_cnt >= closed_len);
        st_d.early = clear_req && !in_window;
        clear_ok   = clear_req && in_window;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign early_reset = st_q.early;
endmodule
